//--- shared/adcc_pkg.sv
/*
  constants shared by the conversion control block: register offsets,
  field positions, reset values, clock source codes and cycle counts.
  assumes a byte-wide register port with a 4-bit word address.
*/
package adcc_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NPINS  = 24;

  localparam logic [3:0] OFS_SC1      = 4'h0;
  localparam logic [3:0] OFS_SC2      = 4'h1;
  localparam logic [3:0] OFS_RES_HIGH = 4'h2;
  localparam logic [3:0] OFS_RES_LOW  = 4'h3;
  localparam logic [3:0] OFS_CMP_HIGH = 4'h4;
  localparam logic [3:0] OFS_CMP_LOW  = 4'h5;
  localparam logic [3:0] OFS_CFG      = 4'h6;
  localparam logic [3:0] OFS_PIN_LOW  = 4'h7;
  localparam logic [3:0] OFS_PIN_MID  = 4'h8;
  localparam logic [3:0] OFS_PIN_HIGH = 4'h9;

  localparam int unsigned SC1_CONVERSION_COMPLETE_FLAG_BIT  = 7;
  localparam int unsigned SC1_COMPLETION_IRQ_ENABLE_BIT  = 6;
  localparam int unsigned SC1_CONT_BIT  = 5;
  localparam int unsigned SC2_BUSY_BIT  = 7;
  localparam int unsigned SC2_HWTRG_BIT = 6;
  localparam int unsigned SC2_CMPEN_BIT = 5;
  localparam int unsigned SC2_CMPGT_BIT = 4;
  localparam int unsigned CFG_DIV_LSB   = 5;
  localparam int unsigned CFG_LSMP_BIT  = 4;
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam int unsigned CFG_CLK_LSB   = 0;

  typedef enum logic [1:0] {
    ADCC_SRC_BUS   = 2'b00,
    ADCC_SRC_HALF  = 2'b01,
    ADCC_SRC_ALT   = 2'b10,
    ADCC_SRC_ASYNC = 2'b11
  } adcc_clk_src_t;

  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'b00,
    ADCC_SAMPLE  = 2'b01,
    ADCC_CONVERT = 2'b10
  } adcc_state_t;

  localparam logic [1:0]  MODE_8BIT     = 2'b00;
  localparam logic [1:0]  MODE_10BIT    = 2'b10;
  localparam logic [4:0]  CHAN_ALL_ONES = 5'h1f;
  localparam logic [4:0]  CHAN_RST      = 5'h1f;
  localparam logic [7:0]  CFG_RST       = 8'h00;
  localparam logic [23:0] PIN_DIS_RST   = 24'h00_0000;
  localparam logic [23:0] PAD_ALLOW_RST = 24'hff_ffff;

  localparam logic [4:0]  SAMPLE_SHORT_TICKS = 5'h03;
  localparam logic [4:0]  SAMPLE_LONG_TICKS  = 5'h17;
  localparam logic [1:0]  CMP_SETTLE_CYC     = 2'h3;
  localparam logic [3:0]  RAW_MSB            = 4'ha;
  localparam logic [3:0]  STOP_BIT_10        = 4'h0;
  localparam logic [3:0]  STOP_BIT_8         = 4'h2;
  localparam logic [10:0] TRIAL_FIRST        = 11'h400;

endpackage

//--- rtl/adcc_clkdiv.sv
/*
  converter clock generator: picks one of four sources and divides it,
  giving a one-cycle tick per converter clock period on sys_clk.
  assumes the alternate and internal async clocks are far slower than sys_clk.
*/
`timescale 1ns/10ps
module adcc_clkdiv (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] src_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       run,
  input  wire logic       alt_clk_pin,
  input  wire logic       async_clk_pin,
  output logic            converter_clock_tick
);

  typedef struct packed {
    logic       alt_s1;
    logic       alt_s2;
    logic       alt_d;
    logic       asy_s1;
    logic       asy_s2;
    logic       asy_d;
    logic       half;
    logic [2:0] cnt;
    logic       tick;
    logic [4:0] gap;
  } adcc_div_t;

  adcc_div_t s_reg;
  adcc_div_t s_next;

  function automatic logic [2:0] adcc_div_mask(input logic [1:0] d);
    unique case (d)
      2'b00: adcc_div_mask = 3'h0;
      2'b01: adcc_div_mask = 3'h1;
      2'b10: adcc_div_mask = 3'h3;
      2'b11: adcc_div_mask = 3'h7;
    endcase
  endfunction

  always_comb begin
    logic src_tick;
    src_tick = 1'b0;
    s_next = s_reg;
    s_next.alt_s1 = alt_clk_pin;
    s_next.alt_s2 = s_reg.alt_s1;
    s_next.alt_d  = s_reg.alt_s2;
    s_next.asy_s1 = async_clk_pin;
    s_next.asy_s2 = s_reg.asy_s1;
    s_next.asy_d  = s_reg.asy_s2;
    s_next.tick   = 1'b0;
    // cycles since the last tick; feeds the divide check only
    if (!run) begin
      s_next.gap = 5'h00;
    end else if (s_reg.tick) begin
      s_next.gap = 5'h01;
    end else if (s_reg.gap != 5'h1f) begin
      s_next.gap = s_reg.gap + 5'h01;
    end
    unique case (adcc_pkg::adcc_clk_src_t'(src_sel))
      adcc_pkg::ADCC_SRC_BUS:   src_tick = 1'b1;
      adcc_pkg::ADCC_SRC_HALF:  src_tick = s_reg.half;
      adcc_pkg::ADCC_SRC_ALT:   src_tick = s_reg.alt_s2 & ~s_reg.alt_d;
      adcc_pkg::ADCC_SRC_ASYNC: src_tick = s_reg.asy_s2 & ~s_reg.asy_d;
    endcase
    if (!run) begin
      s_next.half = 1'b0;
      s_next.cnt  = 3'h0;
    end else begin
      s_next.half = ~s_reg.half;
      if (src_tick) begin
        if (s_reg.cnt == adcc_div_mask(div_sel)) begin
          s_next.cnt  = 3'h0;
          s_next.tick = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign converter_clock_tick = s_reg.tick;

  a_half_div_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n || !run)
    (converter_clock_tick && src_sel == 2'b01 && div_sel == 2'b11) |-> (s_reg.gap == 5'h10))
    else $error("halved bus clock with divide by 8 is not bus clock over 16");

endmodule

//--- rtl/adcc_top.sv
/*
  conversion control of a 10-bit successive-approximation converter:
  register file, trigger handling, sample/convert sequencer, rounding,
  compare gating and pin-disable controls for channels 0 to 23.
  assumes an analog comparator driven by sar_code and a plain register port
  whose master keeps strobes one cycle long and never both at once.
*/
`timescale 1ns/10ps
module adcc_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        hw_trigger_input,
  input  wire logic        alternate_clock,
  input  wire logic        internal_async_clock,
  input  wire logic        cmp_above,
  output logic      [10:0] sar_code,
  output logic             sample_en,
  output logic             conv_irq_req,
  output logic             async_osc_en,
  output logic      [23:0] pad_out_en_allow,
  output logic      [23:0] pad_in_en,
  output logic      [23:0] pad_pullup_allow,
  input  wire logic [23:0] port_in_raw,
  output logic      [23:0] port_in_gated
);

  typedef struct packed {
    adcc_pkg::adcc_state_t state;
    logic                  conversion_complete_flag;
    logic                  completion_irq_enable;
    logic                  cont;
    logic [4:0]            chan;
    logic                  hwtrg;
    logic                  cmp_en;
    logic                  cmp_gt;
    logic [7:0]            cfg;
    logic [1:0]            cv_hi;
    logic [7:0]            cv_lo;
    logic [7:0]            res_hi;
    logic [7:0]            res_lo;
    logic [23:0]           pin_dis;
    logic [10:0]           sar;
    logic [10:0]           trial;
    logic [3:0]            bit_idx;
    logic [4:0]            samp_cnt;
    logic [1:0]            settle;
    logic                  trig_s1;
    logic                  trig_s2;
    logic                  trig_d;
    logic                  cmp_s1;
    logic                  cmp_s2;
    logic [23:0]           pin_s1;
    logic [23:0]           pin_s2;
    logic [7:0]            rdata;
    logic                  irq;
    logic                  osc_en;
    logic                  smp;
    logic [23:0]           pad_out;
    logic [23:0]           pad_in;
    logic [23:0]           pad_pull;
    logic [23:0]           port_gated;
    logic                  hw_go;
    logic                  done;
  } adcc_regs_t;

  adcc_regs_t s_reg;
  adcc_regs_t s_next;
  logic       converter_clock_tick;
  logic       conv_active;

  assign conv_active = (s_reg.state != adcc_pkg::ADCC_IDLE);

  adcc_clkdiv u_clkdiv (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .src_sel       (s_reg.cfg[adcc_pkg::CFG_CLK_LSB +: 2]),
    .div_sel       (s_reg.cfg[adcc_pkg::CFG_DIV_LSB +: 2]),
    .run           (conv_active),
    .alt_clk_pin   (alternate_clock),
    .async_clk_pin (internal_async_clock),
    .converter_clock_tick     (converter_clock_tick)
  );

  function automatic logic adcc_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] ofs);
    adcc_hit = strobe && (addr == ofs);
  endfunction

  // round half up, saturating so a full-scale raw value cannot wrap to zero
  function automatic logic [9:0] adcc_round(input logic [10:0] raw, input logic ten);
    logic [10:0] s10;
    logic [8:0]  s8;
    s10 = {1'b0, raw[10:1]} + {10'h000, raw[0]};
    s8  = {1'b0, raw[10:3]} + {8'h00, raw[2]};
    if (ten) begin
      adcc_round = s10[10] ? 10'h3ff : s10[9:0];
    end else begin
      adcc_round = {2'b00, (s8[8] ? 8'hff : s8[7:0])};
    end
  endfunction

  always_comb begin
    logic        wr_sc1;
    logic        wr_sc2;
    logic        wr_cfg;
    logic        wr_cvh;
    logic        wr_cvl;
    logic        rd_resl;
    logic        abort;
    logic        sw_start;
    logic        hw_start;
    logic        ten;
    logic        fin;
    logic        xfer;
    logic        cond;
    logic [3:0]  stop_bit;
    logic [4:0]  reload;
    logic [10:0] sar_new;
    logic [9:0]  res10;
    logic [9:0]  cv10;
    s_next = s_reg;
    s_next.hw_go = 1'b0;
    s_next.done  = 1'b0;
    fin     = 1'b0;
    xfer    = 1'b0;
    cond    = 1'b0;
    sar_new = s_reg.sar;
    res10   = 10'h000;
    cv10    = 10'h000;

    s_next.trig_s1 = hw_trigger_input;
    s_next.trig_s2 = s_reg.trig_s1;
    s_next.trig_d  = s_reg.trig_s2;
    s_next.cmp_s1  = cmp_above;
    s_next.cmp_s2  = s_reg.cmp_s1;
    s_next.pin_s1  = port_in_raw;
    s_next.pin_s2  = s_reg.pin_s1;

    wr_sc1  = adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_SC1);
    wr_sc2  = adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_SC2);
    wr_cfg  = adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_CFG);
    wr_cvh  = adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_CMP_HIGH);
    wr_cvl  = adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_CMP_LOW);
    rd_resl = adcc_hit(reg_rd, reg_addr, adcc_pkg::OFS_RES_LOW);
    // any change of mode invalidates a conversion in flight
    abort   = wr_sc1 | wr_sc2 | wr_cfg | wr_cvh | wr_cvl;

    ten      = (s_reg.cfg[adcc_pkg::CFG_MODE_LSB +: 2] == adcc_pkg::MODE_10BIT);
    stop_bit = ten ? adcc_pkg::STOP_BIT_10 : adcc_pkg::STOP_BIT_8;
    reload   = s_reg.cfg[adcc_pkg::CFG_LSMP_BIT] ? adcc_pkg::SAMPLE_LONG_TICKS : adcc_pkg::SAMPLE_SHORT_TICKS;
    sw_start = wr_sc1 && (reg_wdata[4:0] != adcc_pkg::CHAN_ALL_ONES) && !s_reg.hwtrg;
    // edges seen while busy, including a continuous run, fall through here
    hw_start = s_reg.trig_s2 && !s_reg.trig_d && s_reg.hwtrg && !conv_active
               && (s_reg.chan != adcc_pkg::CHAN_ALL_ONES);

    if (s_reg.settle != 2'h0) begin
      s_next.settle = s_reg.settle - 2'h1;
    end

    if (!abort) begin
      unique case (s_reg.state)
        adcc_pkg::ADCC_IDLE: begin
          if (hw_start) begin
            s_next.state    = adcc_pkg::ADCC_SAMPLE;
            s_next.samp_cnt = reload;
            s_next.hw_go    = 1'b1;
          end
        end
        adcc_pkg::ADCC_SAMPLE: begin
          if (converter_clock_tick) begin
            if (s_reg.samp_cnt == 5'h00) begin
              s_next.state   = adcc_pkg::ADCC_CONVERT;
              s_next.bit_idx = adcc_pkg::RAW_MSB;
              s_next.sar     = 11'h000;
              s_next.trial   = adcc_pkg::TRIAL_FIRST;
              s_next.settle  = adcc_pkg::CMP_SETTLE_CYC;
            end else begin
              s_next.samp_cnt = s_reg.samp_cnt - 5'h01;
            end
          end
        end
        adcc_pkg::ADCC_CONVERT: begin
          // settle covers the comparator synchroniser lag after each trial
          if (converter_clock_tick && (s_reg.settle == 2'h0)) begin
            sar_new    = s_reg.cmp_s2 ? s_reg.trial : s_reg.sar;
            s_next.sar = sar_new;
            if (s_reg.bit_idx == stop_bit) begin
              fin = 1'b1;
            end else begin
              s_next.bit_idx = s_reg.bit_idx - 4'h1;
              s_next.trial   = sar_new | (11'h001 << (s_reg.bit_idx - 4'h1));
              s_next.settle  = adcc_pkg::CMP_SETTLE_CYC;
            end
          end
        end
        default: begin
          s_next.state = adcc_pkg::ADCC_IDLE;
        end
      endcase
    end

    if (fin) begin
      res10 = adcc_round(sar_new, ten);
      cv10  = ten ? {s_reg.cv_hi, s_reg.cv_lo} : {2'b00, s_reg.cv_lo};
      cond  = s_reg.cmp_gt ? (res10 >= cv10) : (res10 < cv10);
      xfer  = !s_reg.cmp_en || cond;
      s_next.done  = 1'b1;
      s_next.trial = 11'h000;
      if (xfer) begin
        if (ten) begin
          s_next.res_hi = {6'h00, res10[9:8]};
        end
        s_next.res_lo = res10[7:0];
      end
      if (s_reg.cont) begin
        s_next.state    = adcc_pkg::ADCC_SAMPLE;
        s_next.samp_cnt = reload;
      end else begin
        s_next.state = adcc_pkg::ADCC_IDLE;
      end
    end

    // a completion in the clearing cycle still leaves the flag set
    s_next.conversion_complete_flag = (s_reg.conversion_complete_flag & ~(wr_sc1 | rd_resl)) | xfer;

    if (wr_sc1) begin
      s_next.completion_irq_enable = reg_wdata[adcc_pkg::SC1_COMPLETION_IRQ_ENABLE_BIT];
      s_next.cont = reg_wdata[adcc_pkg::SC1_CONT_BIT];
      s_next.chan = reg_wdata[4:0];
    end
    if (wr_sc2) begin
      s_next.hwtrg  = reg_wdata[adcc_pkg::SC2_HWTRG_BIT];
      s_next.cmp_en = reg_wdata[adcc_pkg::SC2_CMPEN_BIT];
      s_next.cmp_gt = reg_wdata[adcc_pkg::SC2_CMPGT_BIT];
    end
    if (wr_cfg) begin
      s_next.cfg = reg_wdata;
    end
    if (wr_cvh) begin
      s_next.cv_hi = reg_wdata[1:0];
    end
    if (wr_cvl) begin
      s_next.cv_lo = reg_wdata;
    end
    if (adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_PIN_LOW)) begin
      s_next.pin_dis[7:0] = reg_wdata;
    end
    if (adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_PIN_MID)) begin
      s_next.pin_dis[15:8] = reg_wdata;
    end
    if (adcc_hit(reg_wr, reg_addr, adcc_pkg::OFS_PIN_HIGH)) begin
      s_next.pin_dis[23:16] = reg_wdata;
    end
    if (abort) begin
      s_next.trial = 11'h000;
      s_next.state = sw_start ? adcc_pkg::ADCC_SAMPLE : adcc_pkg::ADCC_IDLE;
      s_next.samp_cnt = reload;
    end

    s_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        adcc_pkg::OFS_SC1:      s_next.rdata = {s_reg.conversion_complete_flag, s_reg.completion_irq_enable, s_reg.cont, s_reg.chan};
        adcc_pkg::OFS_SC2:      s_next.rdata = {conv_active, s_reg.hwtrg, s_reg.cmp_en, s_reg.cmp_gt, 4'h0};
        adcc_pkg::OFS_RES_HIGH: s_next.rdata = s_reg.res_hi;
        adcc_pkg::OFS_RES_LOW:  s_next.rdata = s_reg.res_lo;
        adcc_pkg::OFS_CMP_HIGH: s_next.rdata = {6'h00, s_reg.cv_hi};
        adcc_pkg::OFS_CMP_LOW:  s_next.rdata = s_reg.cv_lo;
        adcc_pkg::OFS_CFG:      s_next.rdata = s_reg.cfg;
        adcc_pkg::OFS_PIN_LOW:  s_next.rdata = s_reg.pin_dis[7:0];
        adcc_pkg::OFS_PIN_MID:  s_next.rdata = s_reg.pin_dis[15:8];
        adcc_pkg::OFS_PIN_HIGH: s_next.rdata = s_reg.pin_dis[23:16];
        default:                s_next.rdata = 8'h00;
      endcase
    end

    s_next.irq = s_next.conversion_complete_flag & s_next.completion_irq_enable;
    // no stop input gates this: the oscillator stays on through wait and stop
    s_next.osc_en = (s_next.state != adcc_pkg::ADCC_IDLE)
                    && (s_next.cfg[adcc_pkg::CFG_CLK_LSB +: 2] == adcc_pkg::ADCC_SRC_ASYNC);
    s_next.smp        = (s_next.state == adcc_pkg::ADCC_SAMPLE);
    s_next.pad_out    = ~s_next.pin_dis;
    s_next.pad_in     = ~s_next.pin_dis;
    s_next.pad_pull   = ~s_next.pin_dis;
    s_next.port_gated = s_reg.pin_s2 & ~s_reg.pin_dis;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.state    <= adcc_pkg::ADCC_IDLE;
      s_reg.chan     <= adcc_pkg::CHAN_RST;
      s_reg.cfg      <= adcc_pkg::CFG_RST;
      s_reg.pin_dis  <= adcc_pkg::PIN_DIS_RST;
      s_reg.pad_out  <= adcc_pkg::PAD_ALLOW_RST;
      s_reg.pad_in   <= adcc_pkg::PAD_ALLOW_RST;
      s_reg.pad_pull <= adcc_pkg::PAD_ALLOW_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata        = s_reg.rdata;
  assign sar_code         = s_reg.trial;
  assign sample_en        = s_reg.smp;
  assign conv_irq_req     = s_reg.irq;
  assign async_osc_en     = s_reg.osc_en;
  assign pad_out_en_allow = s_reg.pad_out;
  assign pad_in_en        = s_reg.pad_in;
  assign pad_pullup_allow = s_reg.pad_pull;
  assign port_in_gated    = s_reg.port_gated;

  a_chan_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.chan == adcc_pkg::CHAN_ALL_ONES) |-> !conv_active)
    else $error("converter active with channel select all ones");

  a_single_ends_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.done && !s_reg.cont && !$past(reg_wr)) |-> (s_reg.state == adcc_pkg::ADCC_IDLE))
    else $error("single conversion did not return to idle");

  a_ten_bit_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.done && $rose(s_reg.conversion_complete_flag) && $past(s_reg.cfg[3:2]) == adcc_pkg::MODE_10BIT)
      |-> (s_reg.res_hi[7:2] == 6'h00))
    else $error("10-bit result high has bits above the top two");

  a_eight_bit_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.done && $past(s_reg.cfg[3:2]) == adcc_pkg::MODE_8BIT) |-> $stable(s_reg.res_hi))
    else $error("8-bit conversion changed result high");

  a_flag_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_reg.conversion_complete_flag) |-> ##1 (conv_irq_req == s_reg.completion_irq_enable || $changed(s_reg.conversion_complete_flag) || $changed(s_reg.completion_irq_enable)))
    else $error("interrupt request does not follow flag and enable");

  a_compare_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.done && $past(s_reg.cmp_en) && !$past(s_reg.conversion_complete_flag) && !s_reg.conversion_complete_flag)
      |-> ($stable(s_reg.res_lo) && $stable(s_reg.res_hi)))
    else $error("result registers changed without setting the complete flag");

  a_pins_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 ((pad_out_en_allow == ~s_reg.pin_dis) && (pad_in_en == ~s_reg.pin_dis) && (pad_pullup_allow == ~s_reg.pin_dis)))
    else $error("pad controls disagree with pin-disable bits");

  a_hw_edge_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_reg.hw_go |-> (s_reg.state == adcc_pkg::ADCC_SAMPLE) ##1 (sample_en || !conv_active))
    else $error("hardware trigger did not start sampling");

  a_busy_edge_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.trig_s2 && !s_reg.trig_d && conv_active) |=> !s_reg.hw_go)
    else $error("trigger edge acted on while converting");

  a_sw_write_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == adcc_pkg::OFS_SC1 && reg_wdata[4:0] != 5'h1f && !s_reg.hwtrg)
      |=> (s_reg.state == adcc_pkg::ADCC_SAMPLE && sample_en))
    else $error("software write did not start a conversion");

  a_cont_restarts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.done && $past(s_reg.cont) && !$past(reg_wr)) |-> (s_reg.state == adcc_pkg::ADCC_SAMPLE))
    else $error("continuous mode did not restart");

endmodule

//--- dv/adcc_top_bench.sv
/*
  self-checking bench for adcc_top: pin controls, conversions in every
  clock source, compare gating, hardware trigger and continuous runs.
  assumes the register map and timing given in the design hand-over.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module adcc_top_bench;
  logic        sys_clk, rst_n, reg_wr, reg_rd, hw_trigger_input, aclk, cmp_above, f;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d, h;
  logic [10:0] sar_code, vin;
  logic        sample_en, conv_irq_req, async_osc_en;
  logic [23:0] pad_out_en_allow, pad_in_en, pad_pullup_allow, port_in_raw, port_in_gated;
  int          fail_count, num_checks, cyc;

  adcc_top u_adcc_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger_input(hw_trigger_input),
    .alternate_clock(aclk), .internal_async_clock(aclk), .cmp_above(cmp_above), .sar_code(sar_code),
    .sample_en(sample_en), .conv_irq_req(conv_irq_req), .async_osc_en(async_osc_en),
    .pad_out_en_allow(pad_out_en_allow), .pad_in_en(pad_in_en), .pad_pullup_allow(pad_pullup_allow),
    .port_in_raw(port_in_raw), .port_in_gated(port_in_gated));

  initial begin sys_clk = 1'b0; forever #2 sys_clk = ~sys_clk; end
  // slow free-running source stands in for both alternate and async clocks
  initial begin aclk = 1'b0; forever #20 aclk = ~aclk; end
  // ideal comparator against the trial code
  always @(posedge sys_clk) cmp_above <= (vin >= sar_code);
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin fail_count++; end_sim(); end
  end

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // polls the complete flag; reading control one leaves it set
  task automatic wait_flag;
    f = 1'b0;
    for (int i = 0; i < 300 && f !== 1'b1; i++) begin
      rd(adcc_pkg::OFS_SC1);
      f = d[7];
    end
  endtask
  function automatic logic [9:0] r10(input logic [10:0] v);
    return (&v[10:1]) ? v[10:1] : v[10:1] + 10'(v[0]);
  endfunction
  function automatic logic [7:0] r8(input logic [10:0] v);
    return (&v[10:3]) ? v[10:3] : v[10:3] + 8'(v[2]);
  endfunction
  task automatic run(input logic [10:0] v, input logic [7:0] cfg);
    vin = v;
    wr(adcc_pkg::OFS_CFG, cfg);
    wr(adcc_pkg::OFS_SC1, 8'h40);
    @(negedge sys_clk);
    `CHK("sampling", 1'b1, sample_en)
    repeat (12) @(posedge sys_clk);
    `CHK("osc_on", (cfg[1:0] == 2'b11), async_osc_en)
    wait_flag();
    `CHK("complete", 1'b1, f)
    `CHK("irq", 1'b1, conv_irq_req)
    `CHK("osc_idle", 1'b0, async_osc_en)
    rd(adcc_pkg::OFS_RES_HIGH);
    h = d;
    rd(adcc_pkg::OFS_RES_LOW);
    if (cfg[3]) `CHK("res10", r10(v), {h[1:0], d})
    else `CHK("res8", r8(v), d)
  endtask

  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    hw_trigger_input = 1'b0; vin = 11'h000; port_in_raw = 24'hff_ffff;
    fail_count = 0; num_checks = 0; cyc = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(adcc_pkg::OFS_PIN_MID);
    `CHK("pin_mid_rst", 8'h00, d)
    rd(adcc_pkg::OFS_PIN_HIGH);
    `CHK("pin_high_rst", 8'h00, d)
    `CHK("out_rst", 24'hff_ffff, pad_out_en_allow)
    rd(adcc_pkg::OFS_CFG);
    `CHK("cfg_rst", 8'h00, d)
    wr(adcc_pkg::OFS_PIN_MID, 8'h81);
    wr(adcc_pkg::OFS_PIN_HIGH, 8'h01);
    repeat (4) @(posedge sys_clk);
    `CHK("out_en", 24'hfe_7eff, pad_out_en_allow)
    `CHK("in_en", 24'hfe_7eff, pad_in_en)
    `CHK("pullup", 24'hfe_7eff, pad_pullup_allow)
    `CHK("port_in", 24'hfe_7eff, port_in_gated)
    run(11'h2ab, 8'h08);
    run(11'h7ff, 8'h08);
    run(11'h155, 8'h00);
    run(11'h3c8, 8'h69);
    run(11'h0f3, 8'h0b);
    run(11'h517, 8'h2a);
    run(11'h0c6, 8'h14);
    wr(adcc_pkg::OFS_SC1, 8'h1f);
    repeat (40) @(posedge sys_clk);
    rd(adcc_pkg::OFS_SC2);
    `CHK("off_busy", 1'b0, d[7])
    vin = 11'h100;
    wr(adcc_pkg::OFS_CFG, 8'h08);
    wr(adcc_pkg::OFS_CMP_HIGH, 8'h03);
    wr(adcc_pkg::OFS_CMP_LOW, 8'hff);
    wr(adcc_pkg::OFS_SC2, 8'h30);
    wr(adcc_pkg::OFS_SC1, 8'h00);
    repeat (200) @(posedge sys_clk);
    rd(adcc_pkg::OFS_SC1);
    `CHK("cmp_false", 1'b0, d[7])
    wr(adcc_pkg::OFS_SC2, 8'h20);
    wr(adcc_pkg::OFS_SC1, 8'h00);
    wait_flag();
    `CHK("cmp_true", 1'b1, f)
    rd(adcc_pkg::OFS_RES_LOW);
    `CHK("cmp_res", 8'h80, d)
    wr(adcc_pkg::OFS_SC2, 8'h40);
    wr(adcc_pkg::OFS_SC1, 8'h00);
    hw_trigger_input <= 1'b1;
    repeat (20) @(posedge sys_clk);
    hw_trigger_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // second edge lands while the first conversion is still running
    hw_trigger_input <= 1'b1;
    wait_flag();
    `CHK("hw_start", 1'b1, f)
    hw_trigger_input <= 1'b0;
    rd(adcc_pkg::OFS_RES_LOW);
    `CHK("hw_res", 8'h80, d)
    repeat (100) @(posedge sys_clk);
    rd(adcc_pkg::OFS_SC1);
    `CHK("hw_busy_edge", 1'b0, d[7])
    wr(adcc_pkg::OFS_SC2, 8'h00);
    wr(adcc_pkg::OFS_SC1, 8'h20);
    wait_flag();
    rd(adcc_pkg::OFS_RES_LOW);
    `CHK("cont_res", 8'h80, d)
    wait_flag();
    `CHK("cont_again", 1'b1, f)
    // reset in the middle of a continuous run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("rst_sar", 11'h000, sar_code)
    `CHK("rst_smp", 1'b0, sample_en)
    rst_n <= 1'b1;
    rd(adcc_pkg::OFS_SC2);
    `CHK("rst_busy", 1'b0, d[7])
    rd(adcc_pkg::OFS_PIN_MID);
    `CHK("rst_pin_mid", 8'h00, d)
    wr(adcc_pkg::OFS_SC1, 8'h1f);
    end_sim();
  end
endmodule
